// ===== logic/flash_pkg.sv
// constants and carrier types for the flash strobe controller
// assumes one 125 mhz clock and frame timing pulses from the sensor core
package flash_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] FLASH_CONTROL_ADDR = 8'h23;
	localparam logic [7:0] CONTEXT_CONTROL_ADDR = 8'hc8;

	// ----------------------------------------
	// flash control fields
	// ----------------------------------------
	localparam int STATUS_BIT = 15;
	localparam int XENON_BIT = 13;
	localparam int DELAY_HI = 12;
	localparam int DELAY_LO = 11;
	localparam int ANCHOR_BIT = 10;
	localparam int EVERY_BIT = 9;
	localparam int LED_BIT = 8;
	localparam int COUNT_HI = 7;
	localparam int COUNT_LO = 0;

	// context control aliases
	localparam int CTX_XENON_BIT = 7;
	localparam int CTX_LED_BIT = 2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic XENON_RST = 1'h0;
	localparam logic [1:0] DELAY_RST = 2'h0;
	localparam logic ANCHOR_RST = 1'h1;
	localparam logic EVERY_RST = 1'h1;
	localparam logic LED_RST = 1'h0;
	localparam logic [7:0] COUNT_RST = 8'h08;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int UNIT_CYCLES = 1024;
	localparam logic [9:0] UNIT_LAST = 10'(UNIT_CYCLES - 1);

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic reset_start;
		logic reset_end;
		logic readout_end;
	} frame_evt_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		XS_IDLE = 2'b00,
		XS_WAIT = 2'b01,
		XS_DONE = 2'b10
	} xen_state_t;

endpackage

// ===== logic/pulse_timer.sv
// pulse length timer: high for count x 1024 clock cycles after start
// assumes start is a one-cycle pulse; a count of zero gives no pulse
`timescale 1ns/1ps
module pulse_timer (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic [7:0] count,
	output logic busy
);
	import flash_pkg::*;

	logic [9:0] pre_q;
	logic [7:0] units_q;

	// ----------------------------------------
	// prescaler and unit counter
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pre_q <= 10'h000;
			units_q <= 8'h00;
		end else if (start) begin
			pre_q <= 10'h000;
			units_q <= count;
		end else if (units_q != 8'h00) begin
			if (pre_q == UNIT_LAST) begin
				pre_q <= 10'h000;
				units_q <= units_q - 8'h01;
			end else begin
				pre_q <= pre_q + 10'h001;
			end
		end
	end

	assign busy = (units_q != 8'h00);
endmodule

// ===== logic/flash_strobe_control.sv
// flash strobe controller: xenon pulse and led strobe with register port
// assumes frame events are one-cycle pulses synchronous to sys_clk
`timescale 1ns/1ps
module flash_strobe_control (
	input wire logic sys_clk,
	input wire logic nrst,
	input flash_pkg::reg_req_t req,
	output logic [15:0] rdata,
	input flash_pkg::frame_evt_t evt,
	output logic flash_strobe
);
	import flash_pkg::*;

	logic xen_q;
	logic [1:0] delay_q;
	logic anchor_q;
	logic every_q;
	logic led_q;
	logic [7:0] count_q;
	logic xen_wr;
	logic xen_d;
	logic led_wr;
	logic led_d;
	logic xen_rise;
	xen_state_t xs_q;
	logic [1:0] wait_q;
	logic anchor_evt;
	logic fire;
	logic pulse_busy;
	logic led_on_q;
	logic strobe_q;
	logic [15:0] flash_view;
	logic [15:0] ctx_view;
	logic [15:0] rd_view;
	logic flash_wr;
	logic ctx_wr;
	logic [1:0] delay_d;
	logic strobe_d;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	assign flash_wr = req.wr && (req.addr == FLASH_CONTROL_ADDR);
	assign ctx_wr = req.wr && (req.addr == CONTEXT_CONTROL_ADDR);
	// arming and a new delay in one write must start from the new delay
	assign delay_d = flash_wr ? req.wdata[DELAY_HI:DELAY_LO] : delay_q;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_comb begin
		xen_wr = 1'b0;
		xen_d = xen_q;
		led_wr = 1'b0;
		led_d = led_q;
		if (flash_wr) begin
			xen_wr = 1'b1;
			xen_d = req.wdata[XENON_BIT];
			led_wr = 1'b1;
			led_d = req.wdata[LED_BIT];
		end else if (ctx_wr) begin
			xen_wr = 1'b1;
			xen_d = req.wdata[CTX_XENON_BIT];
			led_wr = 1'b1;
			led_d = req.wdata[CTX_LED_BIT];
		end
	end

	// shared enables: one flop each, seen at both addresses
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			xen_q <= XENON_RST;
			led_q <= LED_RST;
		end else begin
			if (xen_wr) begin
				xen_q <= xen_d;
			end
			if (led_wr) begin
				led_q <= led_d;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			delay_q <= DELAY_RST;
			anchor_q <= ANCHOR_RST;
			every_q <= EVERY_RST;
			count_q <= COUNT_RST;
		end else if (flash_wr) begin
			delay_q <= req.wdata[DELAY_HI:DELAY_LO];
			anchor_q <= req.wdata[ANCHOR_BIT];
			every_q <= req.wdata[EVERY_BIT];
			count_q <= req.wdata[COUNT_HI:COUNT_LO];
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	// bits 15 and 14 have no storage, so writes to them vanish
	always_comb begin
		flash_view = 16'h0000;
		flash_view[STATUS_BIT] = strobe_q;
		flash_view[XENON_BIT] = xen_q;
		flash_view[DELAY_HI:DELAY_LO] = delay_q;
		flash_view[ANCHOR_BIT] = anchor_q;
		flash_view[EVERY_BIT] = every_q;
		flash_view[LED_BIT] = led_q;
		flash_view[COUNT_HI:COUNT_LO] = count_q;
		ctx_view = 16'h0000;
		ctx_view[CTX_XENON_BIT] = xen_q;
		ctx_view[CTX_LED_BIT] = led_q;
	end

	// other context bits live elsewhere in the sensor and read zero here
	always_comb begin
		case (req.addr)
			FLASH_CONTROL_ADDR: rd_view = flash_view;
			CONTEXT_CONTROL_ADDR: rd_view = ctx_view;
			default: rd_view = 16'h0000;
		endcase
	end

	// held between reads so a slow master may fetch it late
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 16'h0000;
		end else if (req.rd) begin
			rdata <= rd_view;
		end
	end

	// ----------------------------------------
	// xenon sequencing
	// ----------------------------------------
	// any write of a 1 to the enable re-arms, so single-shot can be repeated
	assign xen_rise = xen_wr && xen_d;
	assign anchor_evt = anchor_q ? evt.reset_end : evt.readout_end;
	// pulse lands in blanking only if software keeps one-frame integration
	// and a count shorter than blanking; not checked here
	assign fire = (xs_q == XS_WAIT) && xen_q && anchor_evt && (wait_q == 2'h0);

	// idle: disarmed; wait: counting anchors down; done: single shot spent
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			xs_q <= XS_IDLE;
			wait_q <= 2'h0;
		end else if (xen_rise) begin
			xs_q <= XS_WAIT;
			wait_q <= delay_d;
		end else if (!xen_q) begin
			xs_q <= XS_IDLE;
		end else begin
			case (xs_q)
				XS_IDLE: begin
					xs_q <= XS_WAIT;
					wait_q <= delay_d;
				end
				XS_WAIT: begin
					if (anchor_evt && wait_q != 2'h0) begin
						wait_q <= wait_q - 2'h1;
					end else if (fire && !every_q) begin
						xs_q <= XS_DONE;
					end
				end
				XS_DONE: xs_q <= XS_DONE;
				default: xs_q <= XS_IDLE;
			endcase
		end
	end

	// a fire that lands mid-pulse restarts the full length
	pulse_timer u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.start(fire),
		.count(count_q),
		.busy(pulse_busy)
	);

	// ----------------------------------------
	// led strobe
	// ----------------------------------------
	// raised as soon as enabled so it already stands before the next reset
	// hence the frame reset start event needs no decoding here
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			led_on_q <= 1'b0;
		end else if (led_q) begin
			led_on_q <= 1'b1;
		end else if (evt.readout_end) begin
			led_on_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// output
	// ----------------------------------------
	// registered so the pin never glitches while the timer reloads
	assign strobe_d = pulse_busy || led_on_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe_d;
		end
	end

	assign flash_strobe = strobe_q;
endmodule

// ===== test/flash_load.sv
// far-side model: flash driver that times each strobe pulse
// assumes strobe is a level synchronous to sys_clk
`timescale 1ns/1ps
module flash_load (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic flash_strobe,
	output logic [17:0] last_len,
	output logic [7:0] fires
);
	logic [17:0] run_q;
	// driver fires on each rise; a pulse must end inside blanking
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 18'h0;
			last_len <= 18'h0;
			fires <= 8'h0;
		end else begin
			run_q <= flash_strobe ? run_q + 18'h1 : 18'h0;
			if (!flash_strobe && run_q != 18'h0) last_len <= run_q;
			if (flash_strobe && run_q == 18'h0) fires <= fires + 8'h1;
		end
	end
endmodule

// ===== test/flash_monitor.sv
// checker for the flash strobe controller ports
// assumes bind onto flash_strobe_control
`timescale 1ns/1ps
module flash_monitor (
	input wire logic sys_clk,
	input wire logic nrst,
	input flash_pkg::reg_req_t req,
	input wire logic [15:0] rdata,
	input flash_pkg::frame_evt_t evt,
	input wire logic flash_strobe
);
	import flash_pkg::*;
	logic [17:0] len_q;
	logic [2:0] cause_q, ro_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) len_q <= 18'h0;
		else len_q <= flash_strobe ? len_q + 18'h1 : 18'h0;
	end
	// history of anything allowed to raise the strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) cause_q <= 3'h0;
		else cause_q <= {cause_q[1:0], evt.reset_end | evt.readout_end | req.wr};
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) ro_q <= 3'h0;
		else ro_q <= {ro_q[1:0], evt.readout_end};
	end
	// led enable as software last wrote it, at either address
	logic led_en_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) led_en_q <= 1'b0;
		else if (req.wr && req.addr == FLASH_CONTROL_ADDR) led_en_q <= req.wdata[8];
		else if (req.wr && req.addr == CONTEXT_CONTROL_ADDR) led_en_q <= req.wdata[2];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	status_bit_a: assert property (req.rd && req.addr == FLASH_CONTROL_ADDR
		##1 $stable(flash_strobe) |-> rdata[15] == flash_strobe && !rdata[14])
		else $error("status bit wrong");
	rdata_hold_a: assert property (!req.rd && !$past(req.rd) |=> $stable(rdata))
		else $error("read data moved without a read");
	ctx_bits_a: assert property (req.rd && req.addr == CONTEXT_CONTROL_ADDR
		|=> (rdata & 16'hff7b) == 16'h0) else $error("context spare bits set");
	enable_alias_a: assert property (req.wr && req.addr == CONTEXT_CONTROL_ADDR
		##1 req.rd && req.addr == FLASH_CONTROL_ADDR |=> rdata[13] == $past(req.wdata[7], 2)
		&& rdata[8] == $past(req.wdata[2], 2)) else $error("enable alias broken");
	led_on_a: assert property (req.wr && req.addr == FLASH_CONTROL_ADDR
		&& req.wdata[8] |-> ##[1:3] flash_strobe) else $error("led strobe late");
	ctx_led_a: assert property (req.wr && req.addr == CONTEXT_CONTROL_ADDR
		&& req.wdata[2] |-> ##[1:3] flash_strobe) else $error("context led late");
	rise_cause_a: assert property ($rose(flash_strobe) |-> |cause_q[2:1])
		else $error("strobe rose without cause");
	fall_cause_a: assert property ($fell(flash_strobe) |-> |ro_q[2:1]
		|| len_q[9:0] == 10'h0) else $error("strobe fell early");
	led_before_reset_a: assert property (evt.reset_start && $past(led_en_q, 2)
		|-> flash_strobe) else $error("led strobe not up at frame reset");
	cover property ($fell(flash_strobe) && len_q[9:0] == 10'h0);
	cover property ($fell(flash_strobe) && |ro_q[2:1]);
	cover property (req.wr && req.addr == CONTEXT_CONTROL_ADDR);
	cover property (evt.reset_start && flash_strobe);
endmodule
bind flash_strobe_control flash_monitor i_mon (.sys_clk(sys_clk), .nrst(nrst), .req(req),
	.rdata(rdata), .evt(evt), .flash_strobe(flash_strobe));

// ===== test/flash_strobe_control_tb_top.sv
// testbench: register sequences, frame events, strobe checks
// assumes the flash_load model and bound checker
`timescale 1ns/1ps
module flash_strobe_control_tb_top;
	import flash_pkg::*;
	logic sys_clk, nrst, flash_strobe;
	reg_req_t req;
	frame_evt_t evt;
	logic [15:0] rdata, v;
	logic [17:0] last_len;
	logic [7:0] fires, f;
	int mismatches, checked;
	flash_strobe_control i_dut (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata),
		.evt(evt), .flash_strobe(flash_strobe));
	flash_load i_load (.sys_clk(sys_clk), .nrst(nrst), .flash_strobe(flash_strobe),
		.last_len(last_len), .fires(fires));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge sys_clk);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge sys_clk);
		req.rd = 1'b0;
		@(negedge sys_clk);
		d = rdata;
	endtask
	// one frame event: reset end when r, else readout end
	task automatic ev(input logic r);
		evt.reset_start = r;
		evt.reset_end = r;
		evt.readout_end = !r;
		@(negedge sys_clk);
		evt = 3'h0;
	endtask
	task automatic stop_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		nrst = 1'b0;
		req = 26'h0;
		evt = 3'h0;
		mismatches = 0;
		checked = 0;
		repeat (5) @(negedge sys_clk);
		nrst = 1'b1;
		rd(FLASH_CONTROL_ADDR, v);
		chk(v, 16'h0608);
		wr(FLASH_CONTROL_ADDR, 16'hffff);
		rd(CONTEXT_CONTROL_ADDR, v);
		chk(v, 16'h0084);
		idle(2);
		rd(FLASH_CONTROL_ADDR, v);
		chk(v, 16'hbfff);
		wr(CONTEXT_CONTROL_ADDR, 16'h0000);
		rd(FLASH_CONTROL_ADDR, v);
		chk(v, 16'h9eff);
		idle(20);
		chk(flash_strobe, 1'b1);
		ev(1'b0);
		idle(3);
		chk(flash_strobe, 1'b0);
		// each pulse ends well before the next frame event, as in blanking
		for (int a = 0; a < 2; a++) begin
			for (int d = 0; d < 4; d++) begin
				f = fires;
				wr(FLASH_CONTROL_ADDR, {3'h1, 2'(d), 1'(a), 2'h0, 8'(d + 1)});
				ev(a == 0);
				repeat (d) ev(a == 1);
				idle(4);
				chk(fires, f);
				ev(a == 1);
				idle((d + 1) * 1024 + 6);
				chk(last_len, 18'((d + 1) * 1024));
				ev(a == 1);
				idle(4);
				chk(fires, f + 8'h1);
			end
		end
		f = fires;
		wr(FLASH_CONTROL_ADDR, 16'h2601);
		repeat (2) begin
			ev(1'b1);
			idle(1030);
		end
		chk(fires, f + 8'h2);
		wr(CONTEXT_CONTROL_ADDR, 16'h0000);
		ev(1'b1);
		idle(4);
		chk(fires, f + 8'h2);
		wr(CONTEXT_CONTROL_ADDR, 16'h0080);
		ev(1'b1);
		idle(1030);
		chk(fires, f + 8'h3);
		wr(CONTEXT_CONTROL_ADDR, 16'hff7f);
		rd(CONTEXT_CONTROL_ADDR, v);
		chk(v, 16'h0004);
		idle(1);
		chk(flash_strobe, 1'b1);
		ev(1'b1);
		chk(flash_strobe, 1'b1);
		wr(CONTEXT_CONTROL_ADDR, 16'h0000);
		ev(1'b0);
		idle(3);
		chk(flash_strobe, 1'b0);
		wr(8'h24, 16'hffff);
		rd(8'h24, v);
		chk(v, 16'h0000);
		rd(FLASH_CONTROL_ADDR, v);
		chk(v, 16'h0601);
		stop_test;
	end
endmodule
